// ---- common/shb_pkg.sv ----
// Shared constants, encodings and helpers for the SCSI phase host bridge.
package shb_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int BUS_RESET_NS  = 25000;
    // The least hold time rounds up to whole cycles.
    localparam int BUS_RESET_CYC = (BUS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W     = $clog2(BUS_RESET_CYC + 1);

    // ------------------------------------------------------------------
    // Host addresses inside the selected page
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA   = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h41;
    localparam logic [7:0] ADDR_SELECT = 8'h42;
    localparam logic [7:0] ADDR_IRQEN  = 8'h43;
    localparam logic [7:0] ADDR_MASK   = 8'hfc;

    // ------------------------------------------------------------------
    // Transfer phase codes as {MSG, C/D, I/O}, all active low
    // ------------------------------------------------------------------
    localparam logic [2:0] PH_DATA_OUT = 3'h7;
    localparam logic [2:0] PH_DATA_IN  = 3'h6;
    localparam logic [2:0] PH_COMMAND  = 3'h5;
    localparam logic [2:0] PH_STATUS   = 3'h4;
    localparam logic [2:0] PH_MSG_OUT  = 3'h1;
    localparam logic [2:0] PH_MSG_IN   = 3'h0;

    // ------------------------------------------------------------------
    // Status byte layout, a one means the line is asserted
    // ------------------------------------------------------------------
    localparam int STB_MSG = 0;
    localparam int STB_BSY = 1;
    localparam int STB_CD  = 2;
    localparam int STB_IO  = 3;
    localparam int STB_REQ = 4;
    localparam int STB_SEL = 5;
    localparam int STB_RST = 6;
    localparam int STB_IRQ = 7;
    localparam int IRQ_EN_BIT = 0;

    // Bus phase seen from the initiator.
    typedef enum logic [1:0] {
        SHB_BUS_FREE  = 2'b00,
        SHB_SELECTION = 2'b01,
        SHB_INFO_XFER = 2'b10,
        SHB_BUS_RESET = 2'b11
    } shb_state_t;

    // Bus free needs only SEL, BSY and RST to be released.
    function automatic logic shb_bus_free(input logic selOn, input logic bsyOn, input logic rstOn);
        return !selOn && !bsyOn && !rstOn;
    endfunction

endpackage

// ---- dv/shb_host_bridge_tb_top.sv ----
// Self-checking bench for the SCSI phase host bridge.
module shb_host_bridge_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import shb_pkg::*;
    logic clk = 1'b0, arstN = 1'b0, strb = 1'b0, rnw = 1'b1, pgN = 1'b1, hrstN = 1'b1, extRstN = 1'b1;
    logic hOe, irqOut, irqOe, selOut, selOe, rstOut, rstOe, ackOut, ackOe, dOe, tReq, tBsy, tOe;
    logic lastOe = 1'b0, sawSel = 1'b0;
    logic [7:0] addr = 8'h00, hDrv = 8'h00, hOut, dOut, tDat, selData = 8'h00;
    logic [2:0] tPh, xPh;
    shb_state_t ph;
    int nErrors = 0, samplesChecked = 0, cyc = 0;
    wire logic [7:0] busN = (dOe ? dOut : 8'hff) & (tOe ? tDat : 8'hff);
    wire logic selN = selOe ? selOut : 1'b1;
    wire logic rstN = rstOe ? rstOut : extRstN;
    wire logic ackN = ackOe ? ackOut : 1'b1;
    shb_host_bridge i_dut (.clk(clk), .arst_n(arstN), .hostBusTimingStrobe(strb), .hostReadNotWrite(rnw),
        .ioPageSelectN(pgN), .hostSystemResetN(hrstN), .hostAddressLow(addr), .hostDataIn(hOe ? hOut : hDrv),
        .hostDataOut(hOut), .hostDataOe(hOe), .hostInterruptReqNIn(!irqOe), .hostInterruptReqNOut(irqOut),
        .hostInterruptReqNOe(irqOe), .scsiReqN(tReq), .scsiBsyN(tBsy), .scsiMsgN(tPh[2]), .scsiCdN(tPh[1]),
        .scsiIoN(tPh[0]), .scsiSelNIn(selN), .scsiSelNOut(selOut), .scsiSelNOe(selOe), .scsiRstNIn(rstN),
        .scsiRstNOut(rstOut), .scsiRstNOe(rstOe), .scsiAckNOut(ackOut), .scsiAckNOe(ackOe), .scsiDataNIn(busN),
        .scsiDataNOut(dOut), .scsiDataNOe(dOe), .busPhase(ph), .xferPhase(xPh));
    shb_target_model i_tgt (.clk(clk), .selN(selN), .ackN(ackN), .rstN(rstN), .busN(busN), .reqN(tReq),
        .bsyN(tBsy), .phN(tPh), .datN(tDat), .datOe(tOe));
    // ----------------------------------------------------------------
    // Clock, host strobe, selection monitor and hang guard
    // ----------------------------------------------------------------
    initial begin
        forever #4 clk = ~clk;
    end
    // The strobe period is 125 clocks so it stays free-running at 1 MHz.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        strb <= #1 ((cyc % 125) >= 63);
        if (selOe) begin
            sawSel <= 1'b1;
            selData <= busN;
        end
        if (cyc == 30000) begin
            nErrors++;
            final_report;
        end
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic waitPh(input shb_state_t p, input int lim);
        int n;
        n = 0;
        while (ph !== p && n < lim) begin
            @(posedge clk);
            n++;
        end
        #1;
        chk("busPhase", {6'h00, ph}, {6'h00, p});
    endtask
    // One host access timed by the strobe; the read byte is taken as the strobe ends.
    task automatic hacc(input logic [7:0] a, input logic r, input logic [7:0] d, output logic [7:0] q);
        @(posedge strb);
        @(posedge clk);
        #1;
        addr = a;
        rnw = r;
        hDrv = d;
        pgN = 1'b0;
        @(negedge strb);
        @(posedge clk);
        #1;
        q = hOut;
        lastOe = hOe;
        repeat (6) @(posedge clk);
        #1;
        pgN = 1'b1;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic tReset;
        chk("rstDrive", {7'h00, rstOe}, 8'h01);
        waitPh(SHB_BUS_FREE, 3300);
        chk("rstDrive", {7'h00, rstOe}, 8'h00);
        $display("test power-up reset done");
    endtask
    task automatic tSelect;
        logic [7:0] q;
        hacc(ADDR_SELECT, 1'b0, 8'h01, q);
        waitPh(SHB_INFO_XFER, 20);
        chk("selSeen", {7'h00, sawSel}, 8'h01);
        chk("selData", selData, 8'hfe);
        chk("selDrive", {7'h00, selOe}, 8'h00);
        $display("test selection done");
    endtask
    // Every phase code once; message out last, where no ACK may come.
    task automatic tPhases;
        logic [2:0] codes [6];
        logic [7:0] got, q;
        logic ack;
        codes = '{PH_DATA_OUT, PH_DATA_IN, PH_COMMAND, PH_STATUS, PH_MSG_IN, PH_MSG_OUT};
        for (int k = 0; k < 6; k++) begin
            fork
                i_tgt.xfer(codes[k], 8'h3c ^ 8'(k), got, ack);
                begin
                    wait (!tReq);
                    hacc(ADDR_DATA, !codes[k][0], 8'hc0 ^ 8'(k), q);
                end
            join
            chk("phaseCode", {5'h00, xPh}, {5'h00, codes[k]});
            chk("ackGiven", {7'h00, ack}, {7'h00, k < 5});
            if (k < 5 && codes[k][0]) chk("toTarget", got, 8'hc0 ^ 8'(k));
            if (k < 5 && !codes[k][0]) chk("toHost", q, 8'h3c ^ 8'(k));
            chk("busPhase", {6'h00, ph}, {6'h00, SHB_INFO_XFER});
        end
        $display("test transfer phases done");
    endtask
    task automatic tRefuse;
        logic [7:0] q;
        sawSel = 1'b0;
        hacc(ADDR_SELECT, 1'b0, 8'h02, q);
        chk("selWhileBusy", {7'h00, sawSel}, 8'h00);
        hacc(8'h44, 1'b1, 8'h00, q);
        chk("unmappedDrive", {7'h00, lastOe}, 8'h00);
        $display("test refused accesses done");
    endtask
    // Interrupt on REQ, status seen while REQ stands, data read clears it.
    task automatic tIrq;
        logic [7:0] got, q;
        logic ack;
        hacc(ADDR_IRQEN, 1'b0, 8'h01, q);
        fork
            i_tgt.xfer(PH_DATA_IN, 8'h5a, got, ack);
            begin
                wait (!tReq);
                repeat (3) @(posedge clk);
                #1;
                chk("irqDrive", {6'h00, irqOut, irqOe}, 8'h01);
                hacc(ADDR_STATUS, 1'b1, 8'h00, q);
                chk("status", q, 8'h9a);
                hacc(ADDR_DATA, 1'b1, 8'h00, q);
                chk("irqClear", {7'h00, irqOe}, 8'h00);
                chk("irqData", q, 8'h5a);
            end
        join
        chk("irqAck", {7'h00, ack}, 8'h01);
        $display("test interrupt done");
    endtask
    // RST from the far side must end a transfer phase run at once.
    task automatic tTgtRst;
        extRstN = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("tgtRst", {6'h00, ph}, {6'h00, SHB_BUS_FREE});
        extRstN = 1'b1;
        $display("test target reset done");
    endtask
    task automatic tHostReset;
        hrstN = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("busPhase", {6'h00, ph}, {6'h00, SHB_BUS_RESET});
        chk("rstDrive", {7'h00, rstOe}, 8'h01);
        hrstN = 1'b1;
        waitPh(SHB_BUS_FREE, 3300);
        $display("test host reset done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1;
        arstN = 1'b1;
        tReset;
        tSelect;
        tPhases;
        tIrq;
        tRefuse;
        tTgtRst;
        tHostReset;
        final_report;
    end
endmodule

// ---- dv/shb_target_model.sv ----
// Behavioural disc controller acting as bus target for the bridge bench.
module shb_target_model (
    input  wire logic       clk,   // System clock.
    input  wire logic       selN,  // SEL wire level.
    input  wire logic       ackN,  // ACK wire level.
    input  wire logic       rstN,  // RST wire level.
    input  wire logic [7:0] busN,  // Data wire levels.
    output logic            reqN,  // REQ drive.
    output logic            bsyN,  // BSY drive.
    output logic      [2:0] phN,   // MSG, C/D and I/O drive.
    output logic      [7:0] datN,  // Data drive value.
    output logic            datOe  // High while driving data.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released lines float to the terminated high level.
    initial begin
        reqN = 1'b1;
        bsyN = 1'b1;
        phN = 3'h7;
        datN = 8'hff;
        datOe = 1'b0;
    end
    // Answer SEL with BSY; a bus reset drops the target's BSY and REQ at once.
    always @(posedge clk) begin
        if (!rstN) begin
            bsyN <= #1 1'b1;
            reqN <= #1 1'b1;
        end else if (!selN && bsyN && phN[0]) begin
            bsyN <= #1 1'b0;
        end
    end
    // One REQ/ACK byte; the phase lines stay put until ACK is gone again.
    task automatic xfer(input logic [2:0] ph, input logic [7:0] b, output logic [7:0] got, output logic acked);
        int n;
        phN = ph;
        repeat (57) @(posedge clk);
        #1;
        datN = ~b;
        datOe = !ph[0];
        reqN = 1'b0;
        n = 0;
        while (ackN && n < 400) begin
            @(posedge clk);
            n++;
        end
        acked = !ackN;
        got = ~busN;
        #1;
        reqN = 1'b1;
        datOe = 1'b0;
        n = 0;
        while (!ackN && n < 20) begin
            @(posedge clk);
            n++;
        end
    endtask
endmodule

// ---- logic/shb_host_bridge.sv ----
// Initiator bridge between the host 1 MHz expansion bus and a SCSI-style target bus.
//
// Behaviour
// - The bus is in exactly one phase at any time.
// - Reset may cut any phase; bus free follows it and may follow any phase.
// - Phases run bus free, selection, transfer phases, then bus free again.
// - Transfer phases are accepted in any order, repeats included.
// - Bus is free when SEL, BSY and RST are all released.
// - SEL is asserted only after bus free has been seen.
// - SEL drops after BSY; only then may the data lines change.
// - MSG, C/D, I/O select the phase; codes 111,110,101,100,001,000.
// - One byte moves per REQ/ACK handshake.
// - ACK answers REQ with valid data and drops after REQ drops.
// - During transfer phases BSY stays asserted and SEL released.
// - Message-out is unused and need not be serviced.
// - RST clears the bus to bus free at once, over all else except host system reset and bus reset.
// - Bus reset is raised at power-up and on host system reset.
// - Interrupts only pull the shared open-collector line low.
// - Only the four addresses 40 to 43 of the page respond.
// - Host data drive follows read/not-write, only while page selected.
// - Bytes are inverted both ways between host and SCSI data.
// - I/O asserted means target to initiator, released the reverse.
module shb_host_bridge
(
    input  wire logic               clk,                   // 125 MHz system clock.
    input  wire logic               arst_n,                // Asynchronous reset, active low.
    // Host expansion bus.
    input  wire logic               hostBusTimingStrobe,   // Free-running 1 MHz strobe.
    input  wire logic               hostReadNotWrite,      // High for a host read.
    input  wire logic               ioPageSelectN,         // Page select, active low.
    input  wire logic               hostSystemResetN,      // Host system reset, active low.
    input  wire logic [7:0]         hostAddressLow,        // Low address byte.
    input  wire logic [7:0]         hostDataIn,            // Host data bus as seen on the pins.
    output logic      [7:0]         hostDataOut,           // Read data driven to the host.
    output logic                    hostDataOe,            // High while the bridge drives host data.
    input  wire logic               hostInterruptReqNIn,   // Shared interrupt line level.
    output logic                    hostInterruptReqNOut,  // Interrupt drive value, always low.
    output logic                    hostInterruptReqNOe,   // High while pulling the interrupt line.
    // SCSI bus, every line active low and open collector.
    input  wire logic               scsiReqN,              // REQ from the target.
    input  wire logic               scsiBsyN,              // BSY line level.
    input  wire logic               scsiMsgN,              // MSG from the target.
    input  wire logic               scsiCdN,               // C/D from the target.
    input  wire logic               scsiIoN,               // I/O from the target.
    input  wire logic               scsiSelNIn,            // SEL line level.
    output logic                    scsiSelNOut,           // SEL drive value, always low.
    output logic                    scsiSelNOe,            // High while asserting SEL.
    input  wire logic               scsiRstNIn,            // RST line level.
    output logic                    scsiRstNOut,           // RST drive value, always low.
    output logic                    scsiRstNOe,            // High while asserting RST.
    output logic                    scsiAckNOut,           // ACK drive value, always low.
    output logic                    scsiAckNOe,            // High while asserting ACK.
    input  wire logic [7:0]         scsiDataNIn,           // Data line levels.
    output logic      [7:0]         scsiDataNOut,          // Data drive value.
    output logic                    scsiDataNOe,           // High while driving data.
    // Observation.
    output shb_pkg::shb_state_t     busPhase,              // Current bus phase.
    output logic      [2:0]         xferPhase              // Registered {MSG, C/D, I/O} code.
);
    import shb_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    localparam int SYNC_W = 36;
    // Idle levels: strobe low, page deselected, read, host reset released, SCSI lines released.
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {4'h7, 8'h00, 8'h00, 8'hff, 8'hff};

    logic [SYNC_W-1:0] syncVec;
    logic              strobeS;
    logic              pageSelNS;
    logic              rnwS;
    logic              sysRstNS;
    logic [7:0]        addrS;
    logic [7:0]        hostDataS;
    logic [7:0]        scsiCtlNS;
    logic [7:0]        scsiDataNS;

    // Every pin passes two flops; strobe, page select and the SCSI controls included.
    shb_sync #(
        .WIDTH     (SYNC_W),
        .RESET_VAL (SYNC_IDLE)
    ) u_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .asyncIn ({hostBusTimingStrobe, ioPageSelectN, hostReadNotWrite, hostSystemResetN,
                   hostAddressLow, hostDataIn,
                   hostInterruptReqNIn, scsiReqN, scsiBsyN, scsiMsgN, scsiCdN, scsiIoN,
                   scsiSelNIn, scsiRstNIn, scsiDataNIn}),
        .syncOut (syncVec)
    );

    assign {strobeS, pageSelNS, rnwS, sysRstNS, addrS, hostDataS, scsiCtlNS, scsiDataNS} = syncVec;

    // Active-high views of the synchronised SCSI lines.
    logic reqOn;
    logic bsyOn;
    logic msgOn;
    logic cdOn;
    logic ioOn;
    logic selInOn;
    logic rstInOn;
    logic sysRstOn;
    logic [2:0] phaseCode;

    assign reqOn     = !scsiCtlNS[6];
    assign bsyOn     = !scsiCtlNS[5];
    assign msgOn     = !scsiCtlNS[4];
    assign cdOn      = !scsiCtlNS[3];
    assign ioOn      = !scsiCtlNS[2];
    assign selInOn   = !scsiCtlNS[1];
    assign rstInOn   = !scsiCtlNS[0];
    assign sysRstOn  = !sysRstNS;
    assign phaseCode = scsiCtlNS[4:2];

    // ------------------------------------------------------------------
    // Host access decode
    // ------------------------------------------------------------------
    logic strobePrev_reg;
    logic reqPrev_reg;

    // Previous samples for edge detection, both taken from the second stage.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strobePrev_reg <= 1'b0;
            reqPrev_reg    <= 1'b0;
        end else begin
            strobePrev_reg <= strobeS;
            reqPrev_reg    <= reqOn;
        end
    end

    logic pageHit;
    logic strobeFall;
    logic accTake;
    logic wrData;
    logic rdData;
    logic wrSelect;
    logic wrIrqEn;
    logic reqRise;

    // Accesses are taken at the trailing edge of the strobe, when write data is settled.
    assign pageHit    = !pageSelNS && ((addrS & ADDR_MASK) == ADDR_DATA);
    assign strobeFall = strobePrev_reg && !strobeS;
    assign accTake    = strobeFall && pageHit;
    assign wrData     = accTake && !rnwS && (addrS == ADDR_DATA);
    assign rdData     = accTake && rnwS && (addrS == ADDR_DATA);
    assign wrSelect   = accTake && !rnwS && (addrS == ADDR_SELECT);
    assign wrIrqEn    = accTake && !rnwS && (addrS == ADDR_IRQEN);
    assign reqRise    = reqOn && !reqPrev_reg;

    // ------------------------------------------------------------------
    // Bus phase sequencer
    // ------------------------------------------------------------------
    shb_state_t           state_reg;
    shb_state_t           state_next;
    logic [RST_CNT_W-1:0] rstCnt_reg;
    logic [RST_CNT_W-1:0] rstCnt_next;
    logic                 busFree;

    assign busFree = shb_bus_free(selInOn, bsyOn, rstInOn);

    // One state only, so two phases can never be driven together.
    always_comb begin
        state_next  = state_reg;
        rstCnt_next = rstCnt_reg;
        if (sysRstOn) begin
            state_next  = SHB_BUS_RESET;
            rstCnt_next = RST_CNT_W'(BUS_RESET_CYC - 1);
        end else begin
            case (state_reg)
                SHB_BUS_RESET: begin
                    if (rstCnt_reg == '0) begin
                        state_next = SHB_BUS_FREE;
                    end else begin
                        rstCnt_next = rstCnt_reg - 1'b1;
                    end
                end
                SHB_BUS_FREE: begin
                    if (wrSelect && busFree) begin
                        state_next = SHB_SELECTION;
                    end
                end
                SHB_SELECTION: begin
                    if (rstInOn) begin
                        state_next = SHB_BUS_FREE;
                    end else if (bsyOn) begin
                        state_next = SHB_INFO_XFER;
                    end
                end
                SHB_INFO_XFER: begin
                    // Any phase code may follow any other; only BSY loss, RST or host system reset ends the phase run.
                    if (rstInOn || !bsyOn) begin
                        state_next = SHB_BUS_FREE;
                    end
                end
                default: begin
                    state_next = SHB_BUS_FREE;
                end
            endcase
        end
    end

    // Power-up lands in bus reset so the target always starts clean.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg  <= SHB_BUS_RESET;
            rstCnt_reg <= RST_CNT_W'(BUS_RESET_CYC - 1);
        end else begin
            state_reg  <= state_next;
            rstCnt_reg <= rstCnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Handshake, data and interrupt state
    // ------------------------------------------------------------------
    logic       ack_reg;
    logic       ack_next;
    logic [7:0] wrByte_reg;
    logic [7:0] wrByte_next;
    logic       irqEn_reg;
    logic       irqPend_reg;
    logic       irqPend_next;
    logic       ackAllowed;
    logic       inXfer;

    assign inXfer     = (state_reg == SHB_INFO_XFER) && bsyOn && !selInOn;
    // Message-out is left unserviced, so no ACK is given for it.
    assign ackAllowed = inXfer && reqOn && (phaseCode != PH_MSG_OUT);

    // ACK rises on a data access with REQ up and falls once REQ is gone.
    assign ack_next = (state_reg != SHB_INFO_XFER) ? 1'b0 :
                      ((wrData || rdData) && ackAllowed) ? 1'b1 :
                      (!reqOn ? 1'b0 : ack_reg);

    // The select byte stays on the data lines until SEL has dropped.
    assign wrByte_next = ((wrData || wrSelect) && (state_reg != SHB_SELECTION)) ? hostDataS : wrByte_reg;

    // A new REQ while enabled wins over a clearing access in the same cycle.
    assign irqPend_next = (irqEn_reg && reqRise) ? 1'b1 :
                          ((!irqEn_reg || wrData || rdData) ? 1'b0 : irqPend_reg);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg     <= 1'b0;
            wrByte_reg  <= '0;
            irqEn_reg   <= 1'b0;
            irqPend_reg <= 1'b0;
        end else begin
            ack_reg     <= ack_next;
            wrByte_reg  <= wrByte_next;
            irqEn_reg   <= wrIrqEn ? hostDataS[IRQ_EN_BIT] : irqEn_reg;
            irqPend_reg <= irqPend_next;
        end
    end

    // ------------------------------------------------------------------
    // Host read path
    // ------------------------------------------------------------------
    logic [7:0] statusByte;
    logic [7:0] rdByte_next;
    logic [7:0] hostDataOut_reg;

    assign statusByte = {irqPend_reg, rstInOn, selInOn, reqOn, ioOn, cdOn, bsyOn, msgOn};
    // Read data is inverted from the active-low data lines.
    assign rdByte_next = (addrS == ADDR_DATA)   ? ~scsiDataNS :
                         (addrS == ADDR_STATUS) ? statusByte  : 8'h00;

    // Registered every clock, so the host byte follows the addressed source one cycle late.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hostDataOut_reg <= '0;
        end else begin
            hostDataOut_reg <= rdByte_next;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // The host buffer faces the host only on a read while the page is selected.
    assign hostDataOut = hostDataOut_reg;
    assign hostDataOe  = !pageSelNS && rnwS && pageHit && (addrS != ADDR_SELECT)
                         && (addrS != ADDR_IRQEN);

    // Open collector: only ever pull low, never drive high.
    assign hostInterruptReqNOut = 1'b0;
    assign hostInterruptReqNOe  = irqPend_reg;

    assign scsiSelNOut = 1'b0;
    assign scsiSelNOe  = (state_reg == SHB_SELECTION);
    assign scsiRstNOut = 1'b0;
    assign scsiRstNOe  = (state_reg == SHB_BUS_RESET);
    assign scsiAckNOut = 1'b0;
    assign scsiAckNOe  = ack_reg;

    // Data goes out inverted during selection and while I/O points toward the target.
    assign scsiDataNOut = ~wrByte_reg;
    assign scsiDataNOe  = (state_reg == SHB_SELECTION) || (inXfer && !ioOn);

    assign busPhase  = state_reg;
    assign xferPhase = phaseCode;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_one_phase;
        !(scsiSelNOe && (scsiAckNOe || scsiRstNOe));
    endproperty
    a_one_phase: assert property (p_one_phase) else $error("SEL driven with ACK or RST");

    property p_reset_then_free;
        (state_reg == SHB_BUS_RESET) && !sysRstOn && (rstCnt_reg == '0) |=> (state_reg == SHB_BUS_FREE);
    endproperty
    a_reset_then_free: assert property (p_reset_then_free) else $error("bus reset not followed by bus free");

    property p_sel_after_free;
        $rose(scsiSelNOe) |-> $past(busFree) && $past(wrSelect);
    endproperty
    a_sel_after_free: assert property (p_sel_after_free) else $error("SEL raised without bus free");

    property p_sel_drop;
        scsiSelNOe && bsyOn && !rstInOn && !sysRstOn |=> !scsiSelNOe ##0 (state_reg == SHB_INFO_XFER);
    endproperty
    a_sel_drop: assert property (p_sel_drop) else $error("SEL held after BSY");

    property p_ack_needs_req;
        $rose(scsiAckNOe) |-> $past(reqOn) && $past(wrData || rdData);
    endproperty
    a_ack_needs_req: assert property (p_ack_needs_req) else $error("ACK without REQ and access");

    property p_ack_release;
        scsiAckNOe && !reqOn |=> !scsiAckNOe;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ACK held after REQ release");

    property p_rst_clears;
        rstInOn && !sysRstOn && (state_reg != SHB_BUS_RESET) |=> (state_reg == SHB_BUS_FREE);
    endproperty
    a_rst_clears: assert property (p_rst_clears) else $error("RST did not clear the bus");

    property p_host_reset;
        sysRstOn |=> scsiRstNOe [*2];
    endproperty
    a_host_reset: assert property (p_host_reset) else $error("host reset did not raise RST");

    property p_irq_low_only;
        hostInterruptReqNOe |-> !hostInterruptReqNOut && $past(irqEn_reg);
    endproperty
    a_irq_low_only: assert property (p_irq_low_only) else $error("interrupt not low or not enabled");

    property p_host_drive;
        hostDataOe |-> !pageSelNS && rnwS && ((addrS & ADDR_MASK) == ADDR_DATA);
    endproperty
    a_host_drive: assert property (p_host_drive) else $error("host data driven outside a read");

    property p_no_msg_out_ack;
        (phaseCode == PH_MSG_OUT) && !scsiAckNOe |=> !scsiAckNOe;
    endproperty
    a_no_msg_out_ack: assert property (p_no_msg_out_ack) else $error("ACK given in message-out");

    c_selection: cover property ((state_reg == SHB_SELECTION) ##1 (state_reg == SHB_INFO_XFER));
    c_handshake: cover property ($rose(scsiAckNOe) ##[1:200] $fell(scsiAckNOe));
    c_interrupt: cover property ($rose(hostInterruptReqNOe));
    c_target_rst: cover property ((state_reg == SHB_INFO_XFER) && rstInOn);

endmodule

// ---- logic/shb_sync.sv ----
// Two flip-flop synchroniser for a vector of unrelated levels.
module shb_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,     // System clock.
    input  wire logic             arst_n,  // Asynchronous reset, active low.
    input  wire logic [WIDTH-1:0] asyncIn, // Levels from outside the clock domain.
    output logic      [WIDTH-1:0] syncOut  // Levels safe to use in the clock domain.
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // The first stage feeds only the second one, so metastability settles there.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg <= RESET_VAL;
            stage2_reg <= RESET_VAL;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;

endmodule
